/* src/press_supervisor_map.vh */
// register map, field positions and timing constants of the press stroke supervisor
`ifndef PRESS_SUPERVISOR_MAP_VH
`define PRESS_SUPERVISOR_MAP_VH
// word addresses (byte address / 4)
`define REG_CTRL 4'h0
`define REG_PRESET 4'h1
`define REG_COUNT 4'h2
`define REG_STOPLIM 4'h3
`define REG_STOPTIME 4'h4
`define REG_MICRO 4'h5
`define REG_CAM0 4'h6
`define REG_CAM1 4'h7
`define REG_STATUS 4'h8
`define REG_FAULT 4'h9
`define REG_DISPLAY 4'hA
`define REG_ID 4'hB
// control fields
`define CTRL_CNT_OPT 0
`define CTRL_COMP_EN 1
`define CTRL_MICRO_EN 2
`define CTRL_TEST90 3
`define CTRL_CLR_BRAKE 4
// status fields
`define ST_STOP 0
`define ST_INTR 1
`define ST_BRAKE_WARN 2
`define ST_BRAKE_FAIL 3
`define ST_LOCKOUT 4
`define ST_FAULT 5
// fault code fields: [9:8] letter, [7:0] number
`define LETTER_NONE 2'h0
`define LETTER_E 2'h1
`define LETTER_F 2'h2
`define LETTER_H 2'h3
`define AUX_CODE0 8'h31
`define AUX_CODE1 8'h32
`define AUX_CODE2 8'h33
// selector codes
`define SEL_OFF 2'h0
`define SEL_INCH 2'h1
`define SEL_SINGLE 2'h2
`define SEL_CONT 2'h3
// timing
`define CLK_HZ 20000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define WARN_MARGIN_MS 10
`define ANGLE_90 10'h05A
`define ANGLE_360 10'h168
`define LAMP_DEG 11
`define ID_VALUE 32'h0000_5A5A
`endif

/* src/press_stroke_supervisor.v */
// press stroke supervisor: counter, crank clock, brake monitor, inch timing, faults
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`include "press_supervisor_map.vh"
module press_stroke_supervisor #(
    parameter CNT_W = 20,
    parameter MS_CYC = `MS_CYCLES
)(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // avalon-mm slave
    input wire [3:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] i_writedata,
    output reg [31:0] o_readdata,
    output wire o_waitrequest,
    // operator controls and feedback
    input wire [9:0] i_angle,
    input wire [9:0] i_speed,
    input wire [1:0] i_selector,
    input wire i_run_left,
    input wire i_run_right,
    input wire i_estop,
    input wire i_topstop,
    input wire i_reset_select,
    input wire i_motion,
    input wire [1:0] i_aux_stop,
    input wire i_aux_pair_a,
    input wire i_aux_pair_b,
    input wire i_fault_valid,
    input wire [7:0] i_fault_num,
    input wire [1:0] i_fault_letter,
    input wire i_fault_serious,
    // valve, display and cam outputs
    output reg o_dual_valve_output,
    output reg o_stop_cmd,
    output reg [31:0] o_crank_lamps,
    output reg o_intr_lamp,
    output reg o_brake_warn_lamp,
    output reg [9:0] o_segments,
    output reg [23:0] o_readout,
    output reg o_readout_six,
    output reg [1:0] o_cam
);
    reg [31:0] ctrl_q;
    reg [CNT_W-1:0] preset_q, count_q;
    reg [15:0] stoplim_q, micro_q, stoptime_q, ms_time_q;
    reg [19:0] cam0_q, cam1_q;
    reg [23:0] ms_div_q;
    reg [9:0] angle_prev_q;
    reg [3:0] seg_q;
    reg intr_q, restore_inch_q, brake_warn_q, brake_fail_q, lock_q, fault_q, saw_off_q;
    reg stop_q, timing_q, test_arm_q, rs_prev_q, inch_prev_q, flash_q;
    reg [9:0] code_q;
    reg [15:0] micro_cnt_q;
    reg [23:0] micro_div_q;
    reg [22:0] flash_div_q;
    reg ack_q;
    wire both_run = i_run_left & i_run_right;
    wire top_cross = (angle_prev_q > i_angle) && i_motion;
    wire rs_edge = i_reset_select & ~rs_prev_q;
    wire aux_pair_bad = i_aux_pair_a ^ i_aux_pair_b;
    wire aux_any = |i_aux_stop | ~i_aux_pair_a | aux_pair_bad;
    wire cnt_opt = ctrl_q[`CTRL_CNT_OPT];
    wire [9:0] comp_angle = ctrl_q[`CTRL_COMP_EN] ? i_speed : 10'h000;
    wire [9:0] ts_on = (ctrl_q[25:16] > comp_angle) ? ctrl_q[25:16] - comp_angle : 10'h000;
    wire [1:0] mode = intr_q ? (restore_inch_q ? `SEL_INCH : `SEL_SINGLE) : i_selector;
    // a write lands on the edge after the one that ends the wait state
    wire wr = i_write & ack_q;
    wire [9:0] lamp_div = i_angle / 10'h00B;
    wire [9:0] lamp_idx = (lamp_div > 10'h01F) ? 10'h01F : lamp_div;
    assign o_waitrequest = (i_read | i_write) & ~ack_q;

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait state, unmapped reads zero
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ack_q <= 1'b0;
            o_readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= (i_read | i_write) & ~ack_q;
            // read data only move when a read is taken, then stand
            if (i_read && !ack_q)
            case (i_address)
                `REG_CTRL: o_readdata <= ctrl_q;
                `REG_PRESET: o_readdata <= {{(32-CNT_W){1'b0}}, preset_q};
                `REG_COUNT: o_readdata <= {{(32-CNT_W){1'b0}}, count_q};
                `REG_STOPLIM: o_readdata <= {16'h0000, stoplim_q};
                `REG_STOPTIME: o_readdata <= {16'h0000, stoptime_q};
                `REG_MICRO: o_readdata <= {16'h0000, micro_q};
                `REG_CAM0: o_readdata <= {12'h000, cam0_q};
                `REG_CAM1: o_readdata <= {12'h000, cam1_q};
                `REG_STATUS: o_readdata <= {26'h000_0000, fault_q, lock_q, brake_fail_q,
                    brake_warn_q, intr_q, stop_q};
                `REG_FAULT: o_readdata <= {22'h00_0000, code_q};
                `REG_DISPLAY: o_readdata <= {28'h000_0000, seg_q};
                `REG_ID: o_readdata <= `ID_VALUE;
                default: o_readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ctrl_q <= 32'h0000_0000;
            preset_q <= {CNT_W{1'b0}};
            stoplim_q <= 16'h00C8;
            micro_q <= 16'h0032;
            cam0_q <= 20'h0000_0;
            cam1_q <= 20'h0000_0;
        end
        else if (wr)
        begin
            case (i_address)
                `REG_CTRL: ctrl_q <= i_writedata;
                `REG_PRESET: preset_q <= i_writedata[CNT_W-1:0];
                `REG_STOPLIM: stoplim_q <= i_writedata[15:0];
                `REG_MICRO: micro_q <= i_writedata[15:0];
                `REG_CAM0: cam0_q <= i_writedata[19:0];
                `REG_CAM1: cam1_q <= i_writedata[19:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stroke counter, interrupted stroke, segment selection
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            count_q <= {{(CNT_W-1){1'b0}}, 1'b1};
            angle_prev_q <= 10'h000;
            rs_prev_q <= 1'b0;
            intr_q <= 1'b0;
            restore_inch_q <= 1'b0;
            seg_q <= 4'h0;
        end
        else
        begin
            angle_prev_q <= i_angle;
            rs_prev_q <= i_reset_select;
            if (rs_edge && cnt_opt)
                count_q <= {{(CNT_W-1){1'b0}}, 1'b1};
            else if (top_cross)
                count_q <= count_q + 1'b1;
            if (rs_edge)
            begin
                if (seg_q == (cnt_opt ? 4'h9 : 4'h7))
                    seg_q <= 4'h0;
                else if (i_selector != `SEL_INCH && seg_q == 4'h3)
                    seg_q <= cnt_opt ? 4'h8 : 4'h0;
                else
                    seg_q <= seg_q + 4'h1;
            end
            if (i_estop && i_motion && !intr_q)
            begin
                intr_q <= 1'b1;
                restore_inch_q <= (i_selector == `SEL_INCH);
            end
            else if (intr_q && both_run && top_cross)
                intr_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // brake monitor and ninety-degree test
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            timing_q <= 1'b0;
            ms_div_q <= 24'h00_0000;
            ms_time_q <= 16'h0000;
            stoptime_q <= 16'h0000;
            brake_warn_q <= 1'b0;
            brake_fail_q <= 1'b0;
            test_arm_q <= 1'b0;
        end
        else
        begin
            test_arm_q <= ctrl_q[`CTRL_TEST90] && i_selector == `SEL_CONT;
            if (!timing_q && i_motion && (i_topstop || top_cross ||
                (test_arm_q && i_angle >= `ANGLE_90 && angle_prev_q < `ANGLE_90)))
            begin
                timing_q <= 1'b1;
                ms_div_q <= 24'h00_0000;
                ms_time_q <= 16'h0000;
            end
            else if (timing_q)
            begin
                if (!i_motion)
                begin
                    timing_q <= 1'b0;
                    stoptime_q <= ms_time_q;
                    if (ms_time_q > stoplim_q)
                        brake_fail_q <= 1'b1;
                    else if (ms_time_q + `WARN_MARGIN_MS >= stoplim_q)
                        brake_warn_q <= 1'b1;
                end
                else if (ms_div_q == MS_CYC - 1)
                begin
                    ms_div_q <= 24'h00_0000;
                    ms_time_q <= ms_time_q + 16'h0001;
                end
                else
                    ms_div_q <= ms_div_q + 24'h00_0001;
            end
            if (wr && i_address == `REG_CTRL && i_writedata[`CTRL_CLR_BRAKE])
                brake_fail_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // faults, lockout and stop command
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fault_q <= 1'b0;
            lock_q <= 1'b0;
            saw_off_q <= 1'b0;
            code_q <= 10'h000;
            stop_q <= 1'b0;
        end
        else
        begin
            if (i_fault_valid)
            begin
                fault_q <= 1'b1;
                code_q <= {i_fault_letter, i_fault_num};
                if (i_fault_serious)
                    lock_q <= 1'b1;
            end
            else if (aux_any && !fault_q)
            begin
                fault_q <= 1'b1;
                code_q <= {`LETTER_E, i_aux_stop[0] ? `AUX_CODE0 :
                    i_aux_stop[1] ? `AUX_CODE1 : `AUX_CODE2};
            end
            else if (rs_edge && !aux_any)
                fault_q <= 1'b0;
            if (i_selector == `SEL_OFF)
                saw_off_q <= 1'b1;
            else if (i_selector == `SEL_INCH && saw_off_q && !fault_q && !i_fault_valid)
            begin
                lock_q <= 1'b0;
                saw_off_q <= 1'b0;
            end
            else if (i_selector != `SEL_INCH)
                saw_off_q <= 1'b0;
            stop_q <= fault_q | lock_q | brake_fail_q | i_estop |
                (cnt_opt && count_q == preset_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // valve and micro-inch timer
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_dual_valve_output <= 1'b0;
            o_stop_cmd <= 1'b0;
            micro_cnt_q <= 16'h0000;
            micro_div_q <= 24'h00_0000;
            inch_prev_q <= 1'b0;
        end
        else
        begin
            inch_prev_q <= both_run;
            o_stop_cmd <= stop_q;
            if (micro_cnt_q == 16'h0000 || micro_div_q == MS_CYC - 1)
                micro_div_q <= 24'h00_0000;
            else
                micro_div_q <= micro_div_q + 24'h00_0001;
            if (stop_q)
            begin
                o_dual_valve_output <= 1'b0;
                micro_cnt_q <= 16'h0000;
            end
            else if (mode == `SEL_INCH && ctrl_q[`CTRL_MICRO_EN])
            begin
                if (both_run && !inch_prev_q && micro_cnt_q == 16'h0000)
                    micro_cnt_q <= micro_q;
                else if (micro_cnt_q != 16'h0000 && micro_div_q == MS_CYC - 1)
                    micro_cnt_q <= micro_cnt_q - 16'h0001;
                o_dual_valve_output <= micro_cnt_q != 16'h0000;
            end
            else if (mode == `SEL_INCH || intr_q)
                o_dual_valve_output <= both_run;
            else
                o_dual_valve_output <= (mode != `SEL_OFF) && (both_run ||
                    (o_dual_valve_output && !(i_topstop && i_angle >= ts_on)));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display, lamps and cams
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            flash_div_q <= 23'h00_0000;
            flash_q <= 1'b0;
            o_crank_lamps <= 32'h0000_0000;
            o_intr_lamp <= 1'b0;
            o_brake_warn_lamp <= 1'b0;
            o_segments <= 10'h000;
            o_readout <= 24'h00_0000;
            o_readout_six <= 1'b0;
            o_cam <= 2'b00;
        end
        else
        begin
            flash_div_q <= flash_div_q + 23'h00_0001;
            if (flash_div_q == 23'h7F_FFFF)
                flash_q <= ~flash_q;
            o_crank_lamps <= 32'h0000_0001 << lamp_idx;
            o_intr_lamp <= intr_q & flash_q;
            o_brake_warn_lamp <= brake_warn_q & flash_q;
            o_segments <= 10'h001 << seg_q;
            o_readout_six <= cnt_opt;
            if (lock_q && !fault_q)
                o_readout <= 24'h00_0C0C;
            else if (fault_q)
                o_readout <= {14'h0000, code_q};
            else if (seg_q == 4'h8)
                o_readout <= {{(24-CNT_W){1'b0}}, count_q};
            else if (seg_q == 4'h9)
                o_readout <= {{(24-CNT_W){1'b0}}, preset_q};
            else if (seg_q == 4'h2)
                o_readout <= {8'h00, stoptime_q};
            else
                o_readout <= {14'h0000, i_angle};
            o_cam[0] <= i_angle >= cam0_q[9:0] && i_angle < cam0_q[19:10];
            o_cam[1] <= i_angle >= cam1_q[9:0] && i_angle < cam1_q[19:10];
        end
    end
endmodule

/* dv/press_supervisor_props.sv */
// assertions on the press stroke supervisor ports
`timescale 1ns/1ns
module press_supervisor_props (
    // clock, reset and bus
    input wire i_clk,
    input wire i_rst,
    input wire [3:0] i_address,
    input wire i_read,
    input wire i_write,
    input wire [31:0] o_readdata,
    input wire o_waitrequest,
    // crank and display
    input wire [9:0] i_angle,
    input wire [31:0] o_crank_lamps,
    input wire [9:0] o_segments,
    input wire [23:0] o_readout,
    input wire o_readout_six
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (i_rst);
a_wait_first: assert property ((i_read || i_write) && !$past(i_read || i_write) |-> o_waitrequest)
    else $error("new request not held off");
a_wait_one: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("more than one wait state");
a_read_unmapped: assert property (i_read && !o_waitrequest && i_address > 4'hB
    |-> o_readdata == 32'h0000_0000) else $error("unmapped read not zero");
a_read_stands: assert property (!(i_read || i_write) && !$past(i_rst) |-> $stable(o_readdata))
    else $error("read data moved while idle");
a_lamp_angle: assert property ($stable(i_angle) && !$past(i_rst)
    |-> o_crank_lamps == (32'h0000_0001 << ((i_angle / 10'h00B > 10'h01F) ? 10'h01F
    : i_angle / 10'h00B))) else $error("wrong lamp");
a_seg_single: assert property ($onehot0(o_segments))
    else $error("several segments lit");
a_seg_extra: assert property (|o_segments[9:8] |-> o_readout_six)
    else $error("extra segment without counter option");
a_readout_narrow: assert property (!o_readout_six |-> o_readout[23:12] == 12'h000)
    else $error("upper digits used on narrow readout");
endmodule
bind press_stroke_supervisor press_supervisor_props props_u (.i_clk, .i_rst, .i_address,
    .i_read, .i_write, .o_readdata, .o_waitrequest, .i_angle, .o_crank_lamps, .o_segments,
    .o_readout, .o_readout_six);

/* dv/press_model.sv */
// crank model of the press behind the valve
`timescale 1ns/1ns
module press_model (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // valve and crank feedback
    input wire i_valve,
    output reg [9:0] o_angle,
    output reg o_motion
);
always @(posedge i_clk)
begin
    if (i_rst)
    begin
        o_angle <= 10'h000;
        o_motion <= 1'b0;
    end
    else
    begin
        // crank turns only while air reaches the clutch
        o_motion <= i_valve;
        if (i_valve)
            o_angle <= (o_angle >= 10'h165) ? 10'h000 : o_angle + 10'h003;
    end
end
endmodule

/* dv/press_stroke_supervisor_tb.sv */
// self-checking bench for the press stroke supervisor
`timescale 1ns/1ns
`include "press_supervisor_map.vh"
module press_stroke_supervisor_tb;
reg i_clk = 1'b0;
reg i_rst = 1'b1;
reg [3:0] i_address = 4'h0;
reg i_read = 1'b0, i_write = 1'b0, i_estop = 1'b0, i_reset_select = 1'b0;
reg i_run_left = 1'b0, i_run_right = 1'b0, i_fault_valid = 1'b0, i_fault_serious = 1'b0;
reg i_aux_pair_a = 1'b1, i_aux_pair_b = 1'b1;
reg [31:0] i_writedata = 32'h0000_0000;
reg [1:0] i_selector = 2'h0, i_aux_stop = 2'h0, i_fault_letter = 2'h0;
reg [7:0] i_fault_num = 8'h00;
wire [31:0] o_readdata, o_crank_lamps;
wire [9:0] i_angle, o_segments;
wire [23:0] o_readout;
wire [1:0] o_cam;
wire o_waitrequest, o_dual_valve_output, o_stop_cmd, o_intr_lamp, o_brake_warn_lamp;
wire o_readout_six, i_motion;
reg [31:0] q;
int num_errors = 0;
int checks_done = 0;
int k;
////////////////////////////////////////////////////////////////////////////////
press_stroke_supervisor #(.MS_CYC(20)) dut_u (
    .i_clk, .i_rst, .i_address, .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest,
    .i_angle, .i_speed(10'h000), .i_selector, .i_run_left, .i_run_right, .i_estop,
    .i_topstop(1'b0), .i_reset_select, .i_motion, .i_aux_stop, .i_aux_pair_a, .i_aux_pair_b,
    .i_fault_valid, .i_fault_num, .i_fault_letter, .i_fault_serious, .o_dual_valve_output,
    .o_stop_cmd, .o_crank_lamps, .o_intr_lamp, .o_brake_warn_lamp, .o_segments, .o_readout,
    .o_readout_six, .o_cam
);
press_model model_u (.i_clk, .i_rst, .i_valve(o_dual_valve_output), .o_angle(i_angle),
    .o_motion(i_motion));
initial
    forever #25 i_clk = ~i_clk;
////////////////////////////////////////////////////////////////////////////////
task chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e)
    begin
        num_errors++;
        $display("BAD %0t got %h expected %h", $time, g, e);
    end
endtask
task bus(input w, input [3:0] a, input [31:0] d);
    @(posedge i_clk);
    i_address <= a;
    i_writedata <= d;
    i_read <= !w;
    i_write <= w;
    do
        @(posedge i_clk);
    while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
endtask
task rd(input [3:0] a, input [31:0] e, input [31:0] m = 32'hFFFF_FFFF);
    bus(1'b0, a, 32'h0000_0000);
    chk(q & m, e);
endtask
// poll a status bit until it reads as expected
task ws(input int b, input e);
    int n;
    n = 0;
    do
    begin
        bus(1'b0, `REG_STATUS, 32'h0000_0000);
        n++;
    end
    while (q[b] !== e && n < 300);
    chk({31'h0, q[b]}, {31'h0, e});
endtask
task btn(input b);
    @(posedge i_clk);
    i_run_left <= b;
    i_run_right <= b;
endtask
task rs;
    @(posedge i_clk);
    i_reset_select <= 1'b1;
    @(posedge i_clk);
    i_reset_select <= 1'b0;
endtask
task vchk(input int n, input e);
    repeat (n) @(negedge i_clk);
    chk({31'h0, o_dual_valve_output}, {31'h0, e});
endtask
task final_report;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (40000) @(posedge i_clk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
end
initial
begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(`REG_COUNT, 32'h0000_0001);
    rd(`REG_ID, `ID_VALUE);
    rd(`REG_STOPLIM, 32'h0000_00C8);
    rd(`REG_MICRO, 32'h0000_0032);
    bus(1'b1, `REG_PRESET, 32'h0000_0003);
    rd(`REG_PRESET, 32'h0000_0003);
    bus(1'b1, 4'hE, 32'h0000_FFFF);
    rd(4'hE, 32'h0000_0000);
    $display("test registers done");
    i_selector <= `SEL_INCH;
    btn(1'b1);
    vchk(4, 1'b1);
    btn(1'b0);
    vchk(4, 1'b0);
    bus(1'b1, `REG_MICRO, 32'h0000_0002);
    bus(1'b1, `REG_CTRL, 32'h0000_0004);
    btn(1'b1);
    repeat (3) @(posedge i_clk);
    btn(1'b0);
    vchk(10, 1'b1);
    vchk(40, 1'b0);
    btn(1'b1);
    vchk(60, 1'b0);
    btn(1'b0);
    $display("test inch done");
    bus(1'b1, `REG_CTRL, 32'h0000_0001);
    vchk(2, 1'b0);
    chk({31'h0, o_readout_six}, 32'h0000_0001);
    i_selector <= `SEL_CONT;
    btn(1'b1);
    ws(`ST_STOP, 1'b1);
    rd(`REG_COUNT, 32'h0000_0003);
    chk({31'h0, o_stop_cmd}, 32'h0000_0001);
    bus(1'b1, `REG_CAM0, 32'h0005_A000);
    vchk(3, 1'b0);
    chk({30'h0, o_cam}, 32'h0000_0001);
    btn(1'b0);
    i_selector <= `SEL_SINGLE;
    rs;
    rd(`REG_COUNT, 32'h0000_0001);
    $display("test counter done");
    for (k = 0; k < 3; k++)
    begin
        @(posedge i_clk);
        if (k < 2)
            i_aux_stop[k] <= 1'b1;
        else
            i_aux_pair_a <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_aux_stop <= 2'h0;
        i_aux_pair_a <= 1'b1;
        rd(`REG_FAULT, {22'h0, `LETTER_E, `AUX_CODE0 + k[7:0]}, 32'h0000_03FF);
        rs;
    end
    for (k = 1; k < 4; k++)
    begin
        @(posedge i_clk);
        i_fault_valid <= 1'b1;
        i_fault_letter <= k[1:0];
        i_fault_num <= 8'h10 + k[7:0];
        i_fault_serious <= (k == 3);
        @(posedge i_clk);
        i_fault_valid <= 1'b0;
        rd(`REG_FAULT, {22'h0, k[1:0], 8'h10 + k[7:0]}, 32'h0000_03FF);
        rs;
    end
    ws(`ST_LOCKOUT, 1'b1);
    i_selector <= `SEL_INCH;
    ws(`ST_LOCKOUT, 1'b1);
    i_selector <= `SEL_OFF;
    repeat (3) @(posedge i_clk);
    i_selector <= `SEL_INCH;
    ws(`ST_LOCKOUT, 1'b0);
    $display("test faults done");
    i_selector <= `SEL_SINGLE;
    btn(1'b1);
    repeat (20) @(posedge i_clk);
    i_estop <= 1'b1;
    @(posedge i_clk);
    i_estop <= 1'b0;
    btn(1'b0);
    ws(`ST_INTR, 1'b1);
    btn(1'b1);
    ws(`ST_INTR, 1'b0);
    btn(1'b0);
    $display("test interrupted stroke done");
    final_report;
end
endmodule
